//--- hw/nlse_alu.sv
module nlse_alu (
    // operation and operands
    input  logic [nlse_pkg::OP_W-1:0]  op,
    input  logic [nlse_pkg::NIB_W-1:0] reg_nib,
    input  logic [nlse_pkg::NIB_W-1:0] mem_nib,
    input  logic [nlse_pkg::NIB_W-1:0] imm,
    // outcome
    output logic [nlse_pkg::NIB_W-1:0] result,
    output logic                       wr_reg,
    output logic                       wr_mem,
    output logic                       skip,
    output logic                       clr_flag
);
    import nlse_pkg::*;

    logic [NIB_W-1:0] masked;
    logic [NIB_W-1:0] diff;

    always_comb begin
        masked  = mem_nib & imm;
        diff    = mem_nib - imm;
        result  = RST_NIB;
        wr_reg  = 1'b0;
        wr_mem  = 1'b0;
        skip    = 1'b0;
        clr_flag = 1'b0;
        case (op)
            OP_OR_RM: begin
                result = reg_nib | mem_nib; // RULE1
                wr_reg = 1'b1;
            end
            OP_OR_MI: begin
                result = mem_nib | imm; // RULE2
                wr_mem = 1'b1;
            end
            OP_AND_RM: begin
                result = reg_nib & mem_nib; // RULE3
                wr_reg = 1'b1;
            end
            OP_AND_MI: begin
                result = mem_nib & imm; // RULE4
                wr_mem = 1'b1;
            end
            OP_XOR_RM: begin
                result = reg_nib ^ mem_nib; // RULE5
                wr_reg = 1'b1;
            end
            OP_XOR_MI: begin
                result = mem_nib ^ imm; // RULE6
                wr_mem = 1'b1;
            end
            OP_SKIP_BITS_SET: begin
                skip     = (masked == imm); // RULE7
                clr_flag = 1'b1; // RULE14
            end
            OP_SKIP_BITS_CLEAR: begin
                skip     = (masked == RST_NIB); // RULE8
                clr_flag = 1'b1; // RULE14
            end
            // difference is only tested, never stored
            OP_SKIP_EQUAL:   skip = (diff == RST_NIB); // RULE10
            OP_SKIP_UNEQUAL: skip = (diff != RST_NIB); // RULE11 RULE12
            default: begin
                result = RST_NIB;
            end
        endcase
    end

endmodule

//--- hw/nlse_exec.sv
// What this block does
// RULE1 - register-with-memory OR writes reg OR mem back into the general register.
// RULE2 - opcode 10110 writes mem OR immediate back into the memory nibble.
// RULE3 - opcode 00100 writes reg AND mem into the general register.
// RULE4 - memory-with-immediate AND writes mem AND immediate back to the same nibble.
// RULE5 - opcode 00101 writes reg XOR mem into the general register.
// RULE6 - opcode 10101 writes mem XOR immediate back into the memory nibble.
// RULE7 - opcode 11110 skips the next instruction when mem AND mask equals the mask.
// RULE8 - opcode 11111 skips the next instruction when mem AND mask is zero.
// RULE9 - a skipped instruction is still fetched but changes nothing.
// RULE10 - opcode 01001 subtracts the immediate without storing and skips on zero.
// RULE11 - opcode 01011 is the compare that skips when memory differs from the immediate.
// RULE12 - the not-equal compare skips only on a difference and stores nothing.
// RULE13 - with the index enable flag set the index register is ORed into the address.
// RULE14 - both bit-test skips clear the compare flag, skip taken or not.
// RULE15 - opcode is bits 15..11, row 10..8, column 7..4, operand 3..0.
module nlse_exec (
    // clock and reset
    input  logic                          clk,
    input  logic                          rst_n,
    // instruction stream from fetch
    input  logic                          instr_valid,
    input  logic [nlse_pkg::INSTR_W-1:0]  instr,
    output logic                          instr_ready_r,
    output logic                          skip_next_r,
    // index addressing
    input  logic                          index_enable_flag,
    input  logic [nlse_pkg::ADDR_W-1:0]   index_register,
    // compare flag
    input  logic                          compare_flag_set,
    output logic                          compare_only_flag_r,
    // data memory
    output logic [nlse_pkg::ADDR_W-1:0]   mem_addr_r,
    input  logic [nlse_pkg::NIB_W-1:0]    mem_rd_data,
    output logic                          mem_we_r,
    output logic [nlse_pkg::NIB_W-1:0]    mem_wdata_r,
    // general register file
    output logic [nlse_pkg::NIB_W-1:0]    reg_addr_r,
    input  logic [nlse_pkg::NIB_W-1:0]    reg_rd_data,
    output logic                          reg_we_r,
    output logic [nlse_pkg::NIB_W-1:0]    reg_wdata_r
);
    import nlse_pkg::*;

    // ========================================================
    // decode of the offered word
    logic                 accept;
    logic [OP_W-1:0]      instr_op;
    logic [ADDR_W-1:0]    instr_addr;
    logic [ADDR_W-1:0]    eff_addr;

    assign accept     = instr_valid && instr_ready_r;
    assign instr_op   = instr[OP_MSB:OP_LSB]; // RULE15
    assign instr_addr = {instr[ROW_MSB:ROW_LSB], instr[COL_MSB:COL_LSB]}; // RULE15
    // bank bits stay outside this block; only row and column are indexed
    assign eff_addr   = index_enable_flag ? (instr_addr | index_register)
                                          : instr_addr; // RULE13

    // ========================================================
    // execution unit
    logic [NIB_W-1:0] alu_result;
    logic             alu_wr_reg;
    logic             alu_wr_mem;
    logic             alu_skip;
    logic             alu_clr_flag;
    logic [OP_W-1:0]  op_r;
    logic [OP_W-1:0]  op_nxt;
    logic [NIB_W-1:0] imm_r;
    logic [NIB_W-1:0] imm_nxt;

    nlse_alu u_alu (
        .op      (op_r),
        .reg_nib (reg_rd_data),
        .mem_nib (mem_rd_data),
        .imm     (imm_r),
        .result  (alu_result),
        .wr_reg  (alu_wr_reg),
        .wr_mem  (alu_wr_mem),
        .skip    (alu_skip),
        .clr_flag (alu_clr_flag)
    );

    // ========================================================
    // sequencer: take, read operands, write back
    nlse_state_t       state_r;
    nlse_state_t       state_nxt;
    logic              ready_nxt;
    logic              skip_nxt;
    logic              compare_nxt;
    logic [ADDR_W-1:0] mem_addr_nxt;
    logic              mem_we_nxt;
    logic [NIB_W-1:0]  mem_wdata_nxt;
    logic [NIB_W-1:0]  reg_addr_nxt;
    logic              reg_we_nxt;
    logic [NIB_W-1:0]  reg_wdata_nxt;

    always_comb begin
        state_nxt     = state_r;
        ready_nxt     = instr_ready_r;
        skip_nxt      = skip_next_r;
        compare_nxt   = compare_only_flag_r;
        op_nxt        = op_r;
        imm_nxt       = imm_r;
        mem_addr_nxt  = mem_addr_r;
        mem_we_nxt    = 1'b0;
        mem_wdata_nxt = mem_wdata_r;
        reg_addr_nxt  = reg_addr_r;
        reg_we_nxt    = 1'b0;
        reg_wdata_nxt = reg_wdata_r;
        case (state_r)
            NLSE_IDLE: begin
                if (accept) begin
                    if (skip_next_r) begin
                        // any word fetched under a skip is dropped whole
                        skip_nxt = 1'b0; // RULE9
                    end else if (nlse_op_known(instr_op)) begin
                        op_nxt       = instr_op;
                        imm_nxt      = instr[IMM_MSB:IMM_LSB];
                        reg_addr_nxt = instr[IMM_MSB:IMM_LSB];
                        mem_addr_nxt = eff_addr; // RULE13
                        ready_nxt    = 1'b0;
                        state_nxt    = NLSE_READ;
                    end
                end
            end
            NLSE_READ: begin
                // read ports answer combinationally to the held addresses
                mem_we_nxt    = alu_wr_mem;
                mem_wdata_nxt = alu_result;
                reg_we_nxt    = alu_wr_reg;
                reg_wdata_nxt = alu_result;
                skip_nxt      = alu_skip; // RULE7 RULE8 RULE10 RULE12
                if (alu_clr_flag) begin
                    compare_nxt = 1'b0; // RULE14
                end
                state_nxt = NLSE_WRITE;
            end
            NLSE_WRITE: begin
                ready_nxt = 1'b1;
                state_nxt = NLSE_IDLE;
            end
            default: begin
                ready_nxt = 1'b1;
                state_nxt = NLSE_IDLE;
            end
        endcase
        // an outside set in the clearing cycle is kept
        if (compare_flag_set) begin
            compare_nxt = 1'b1; // RULE14
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r             <= NLSE_IDLE;
            instr_ready_r       <= 1'b1;
            skip_next_r         <= 1'b0;
            compare_only_flag_r <= 1'b0;
            op_r                <= RST_OP;
            imm_r               <= RST_NIB;
            mem_addr_r          <= RST_ADDR;
            mem_we_r            <= 1'b0;
            mem_wdata_r         <= RST_NIB;
            reg_addr_r          <= RST_NIB;
            reg_we_r            <= 1'b0;
            reg_wdata_r         <= RST_NIB;
        end else begin
            state_r             <= state_nxt;
            instr_ready_r       <= ready_nxt;
            skip_next_r         <= skip_nxt;
            compare_only_flag_r <= compare_nxt;
            op_r                <= op_nxt;
            imm_r               <= imm_nxt;
            mem_addr_r          <= mem_addr_nxt;
            mem_we_r            <= mem_we_nxt;
            mem_wdata_r         <= mem_wdata_nxt;
            reg_addr_r          <= reg_addr_nxt;
            reg_we_r            <= reg_we_nxt;
            reg_wdata_r         <= reg_wdata_nxt;
        end
    end

    // ========================================================
    // checks
    logic in_read;
    assign in_read = (state_r == NLSE_READ);

    a_or_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_OR_RM |=> reg_we_r && !mem_we_r &&
        reg_wdata_r == ($past(reg_rd_data) | $past(mem_rd_data))) // RULE1
        else $error("or reg,mem wrong result");

    a_or_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_OR_MI |=> mem_we_r && !reg_we_r &&
        mem_wdata_r == ($past(mem_rd_data) | imm_r)) // RULE2
        else $error("or mem,imm wrong result");

    a_and_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_AND_RM |=> reg_we_r &&
        reg_wdata_r == ($past(reg_rd_data) & $past(mem_rd_data))) // RULE3
        else $error("and reg,mem wrong result");

    a_and_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_AND_MI |=> mem_we_r &&
        mem_wdata_r == ($past(mem_rd_data) & imm_r)) // RULE4
        else $error("and mem,imm wrong result");

    a_xor_reg_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_XOR_RM |=> reg_we_r &&
        reg_wdata_r == ($past(reg_rd_data) ^ $past(mem_rd_data))) // RULE5
        else $error("xor reg,mem wrong result");

    a_xor_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_XOR_MI |=> mem_we_r &&
        mem_wdata_r == ($past(mem_rd_data) ^ imm_r)) // RULE6
        else $error("xor mem,imm wrong result");

    a_bits_set_skip: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_SKIP_BITS_SET |=> !mem_we_r && !reg_we_r &&
        skip_next_r == (($past(mem_rd_data) & imm_r) == imm_r)) // RULE7
        else $error("bit-set skip decision wrong");

    a_bits_clr_skip: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_SKIP_BITS_CLEAR |=> !mem_we_r &&
        skip_next_r == (($past(mem_rd_data) & imm_r) == RST_NIB)) // RULE8
        else $error("bit-clear skip decision wrong");

    a_skipped_is_nop: assert property (@(posedge clk) disable iff (!rst_n)
        accept && skip_next_r |=> state_r == NLSE_IDLE && !skip_next_r ##0
        (!mem_we_r && !reg_we_r) [*2]) // RULE9
        else $error("skipped word had an effect");

    a_equal_skip: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_SKIP_EQUAL |=> !mem_we_r && !reg_we_r &&
        skip_next_r == ($past(mem_rd_data) == imm_r)) // RULE10
        else $error("equal compare skip wrong");

    a_unequal_skip: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && op_r == OP_SKIP_UNEQUAL |=> !mem_we_r && !reg_we_r &&
        skip_next_r == ($past(mem_rd_data) != imm_r)) // RULE11 RULE12
        else $error("unequal compare skip wrong");

    a_index_address: assert property (@(posedge clk) disable iff (!rst_n)
        accept && !skip_next_r && nlse_op_known(instr_op) |=>
        mem_addr_r == ($past(index_enable_flag) ?
            ($past(instr_addr) | $past(index_register)) : $past(instr_addr))) // RULE13
        else $error("effective address wrong");

    a_compare_cleared: assert property (@(posedge clk) disable iff (!rst_n)
        in_read && !compare_flag_set &&
        (op_r == OP_SKIP_BITS_SET || op_r == OP_SKIP_BITS_CLEAR)
        |=> !compare_only_flag_r) // RULE14
        else $error("bit test left compare flag set");

    // an outside set must beat the bit-test clear in the same cycle
    a_compare_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        compare_flag_set |=> compare_only_flag_r) // RULE14
        else $error("outside set of compare flag lost");

    a_field_decode: assert property (@(posedge clk) disable iff (!rst_n)
        accept && !skip_next_r && nlse_op_known(instr_op) |=>
        op_r == $past(instr[OP_MSB:OP_LSB]) &&
        reg_addr_r == $past(instr[IMM_MSB:IMM_LSB]) ##2 instr_ready_r) // RULE15
        else $error("field decode or sequencing wrong");

endmodule

//--- pkg/nlse_pkg.sv
package nlse_pkg;

    // ========================================================
    // instruction word layout
    localparam int INSTR_W = 16;
    localparam int OP_MSB  = 15;
    localparam int OP_LSB  = 11;
    localparam int ROW_MSB = 10;
    localparam int ROW_LSB = 8;
    localparam int COL_MSB = 7;
    localparam int COL_LSB = 4;
    localparam int IMM_MSB = 3;
    localparam int IMM_LSB = 0;

    // ========================================================
    // widths and reset values
    localparam int NIB_W  = 4;
    localparam int ADDR_W = 7;
    localparam int OP_W   = 5;
    localparam logic [NIB_W-1:0]  RST_NIB  = 4'h0;
    localparam logic [ADDR_W-1:0] RST_ADDR = 7'h00;
    localparam logic [OP_W-1:0]   RST_OP   = 5'h00;

    // ========================================================
    // operation codes
    localparam logic [OP_W-1:0] OP_OR_RM   = 5'h06;
    localparam logic [OP_W-1:0] OP_OR_MI   = 5'h16;
    localparam logic [OP_W-1:0] OP_AND_RM  = 5'h04;
    localparam logic [OP_W-1:0] OP_AND_MI  = 5'h14;
    localparam logic [OP_W-1:0] OP_XOR_RM  = 5'h05;
    localparam logic [OP_W-1:0] OP_XOR_MI  = 5'h15;
    localparam logic [OP_W-1:0] OP_SKIP_BITS_SET   = 5'h1e;
    localparam logic [OP_W-1:0] OP_SKIP_BITS_CLEAR = 5'h1f;
    localparam logic [OP_W-1:0] OP_SKIP_EQUAL      = 5'h09;
    localparam logic [OP_W-1:0] OP_SKIP_UNEQUAL    = 5'h0b;

    // ========================================================
    // sequencer states
    typedef enum logic [2:0] {
        NLSE_IDLE  = 3'b001,
        NLSE_READ  = 3'b010,
        NLSE_WRITE = 3'b100
    } nlse_state_t;

    function automatic logic nlse_op_known(input logic [OP_W-1:0] op);
        case (op)
            OP_OR_RM, OP_OR_MI, OP_AND_RM, OP_AND_MI, OP_XOR_RM, OP_XOR_MI,
            OP_SKIP_BITS_SET, OP_SKIP_BITS_CLEAR,
            OP_SKIP_EQUAL, OP_SKIP_UNEQUAL: nlse_op_known = 1'b1;
            default:                        nlse_op_known = 1'b0;
        endcase
    endfunction

endpackage

//--- tb/nlse_mem_model.sv
module nlse_mem_model (
    // clock
    input  logic                         clk,
    // data memory
    input  logic [nlse_pkg::ADDR_W-1:0]  mem_addr,
    output logic [nlse_pkg::NIB_W-1:0]   mem_rd_data,
    input  logic                         mem_we,
    input  logic [nlse_pkg::NIB_W-1:0]   mem_wdata,
    // general registers
    input  logic [nlse_pkg::NIB_W-1:0]   reg_addr,
    output logic [nlse_pkg::NIB_W-1:0]   reg_rd_data,
    input  logic                         reg_we,
    input  logic [nlse_pkg::NIB_W-1:0]   reg_wdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import nlse_pkg::*;

    // ========================================================
    // storage, preloaded by the bench
    logic [NIB_W-1:0] mem [128];
    logic [NIB_W-1:0] rf  [16];

    // reads answer at once, as the core expects
    assign mem_rd_data = mem[mem_addr];
    assign reg_rd_data = rf[reg_addr];

    always @(posedge clk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (reg_we === 1'b1) begin
            rf[reg_addr] <= reg_wdata;
        end
    end
endmodule

//--- tb/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import nlse_pkg::*;

    // ========================================================
    // signals
    logic                clk = 1'b0;
    logic                rst_n = 1'b0;
    logic                instr_valid = 1'b0;
    logic [INSTR_W-1:0]  instr = 16'h0000;
    logic                index_enable_flag = 1'b0;
    logic [ADDR_W-1:0]   index_register = 7'h00;
    logic                compare_flag_set = 1'b0;
    logic                instr_ready_r, skip_next_r, compare_only_flag_r;
    logic [ADDR_W-1:0]   mem_addr_r;
    logic [NIB_W-1:0]    mem_rd_data, mem_wdata_r, reg_addr_r, reg_rd_data, reg_wdata_r;
    logic                mem_we_r, reg_we_r;
    int                  n_mismatch = 0;
    int                  checks = 0;
    logic [NIB_W-1:0]    mem_s [128];
    logic [NIB_W-1:0]    reg_s [16];
    logic                skip_s = 1'b0;
    logic [OP_W-1:0]     ops [10] = '{OP_OR_RM, OP_OR_MI, OP_AND_RM, OP_AND_MI, OP_XOR_RM,
        OP_XOR_MI, OP_SKIP_BITS_SET, OP_SKIP_BITS_CLEAR, OP_SKIP_EQUAL, OP_SKIP_UNEQUAL};

    always #2 clk = ~clk;

    nlse_exec u_dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .instr_ready_r(instr_ready_r), .skip_next_r(skip_next_r),
        .index_enable_flag(index_enable_flag), .index_register(index_register),
        .compare_flag_set(compare_flag_set), .compare_only_flag_r(compare_only_flag_r),
        .mem_addr_r(mem_addr_r), .mem_rd_data(mem_rd_data), .mem_we_r(mem_we_r),
        .mem_wdata_r(mem_wdata_r), .reg_addr_r(reg_addr_r), .reg_rd_data(reg_rd_data),
        .reg_we_r(reg_we_r), .reg_wdata_r(reg_wdata_r));

    nlse_mem_model u_mem (.clk(clk), .mem_addr(mem_addr_r), .mem_rd_data(mem_rd_data),
        .mem_we(mem_we_r), .mem_wdata(mem_wdata_r), .reg_addr(reg_addr_r),
        .reg_rd_data(reg_rd_data), .reg_we(reg_we_r), .reg_wdata(reg_wdata_r));

    // ========================================================
    // helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        checks++;
        if (seen !== expd) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic wait_ready;
        int n;
        n = 0;
        while (instr_ready_r !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h00, instr_ready_r}, 8'h01);
    endtask

    // expected {skip, memory nibble, register nibble} after one executed word
    function automatic logic [8:0] expect_op(input logic [4:0] op, input logic [3:0] m,
                                             input logic [3:0] r, input logic [3:0] imm);
        logic [3:0] em;
        logic [3:0] er;
        logic       es;
        em = m;
        er = r;
        es = 1'b0;
        case (op)
            OP_OR_RM:           er = r | m;
            OP_OR_MI:           em = m | imm;
            OP_AND_RM:          er = r & m;
            OP_AND_MI:          em = m & imm;
            OP_XOR_RM:          er = r ^ m;
            OP_XOR_MI:          em = m ^ imm;
            OP_SKIP_BITS_SET:   es = (m & imm) == imm;
            OP_SKIP_BITS_CLEAR: es = (m & imm) == 4'h0;
            OP_SKIP_EQUAL:      es = (m - imm) == 4'h0;
            OP_SKIP_UNEQUAL:    es = m != imm;
            default: ;
        endcase
        return {es, em, er};
    endfunction

    // reference step: works out what the word must do, sends it, compares
    task automatic run_op(input logic [4:0] op, input logic [2:0] row,
                          input logic [3:0] col, input logic [3:0] imm);
        logic [ADDR_W-1:0] a;
        logic [NIB_W-1:0]  m, r, em, er;
        logic              es;
        wait_ready();
        a = {row, col} | (index_enable_flag ? index_register : 7'h00);
        m = mem_s[a];
        r = reg_s[imm];
        em = m;
        er = r;
        es = 1'b0;
        // a pending skip drops the word whatever it is
        if (!skip_s) begin
            {es, em, er} = expect_op(op, m, r, imm);
        end
        instr = {op, row, col, imm};
        instr_valid = 1'b1;
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        wait_ready();
        @(posedge clk);
        #1;
        mem_s[a] = em;
        reg_s[imm] = er;
        skip_s = es;
        check({4'h0, u_mem.mem[a]}, {4'h0, em});
        check({4'h0, u_mem.rf[imm]}, {4'h0, er});
        check({7'h00, skip_next_r}, {7'h00, es});
    endtask

    // ========================================================
    // main sequence
    initial begin
        logic [4:0] op;
        logic       ef;
        void'($urandom(32'h852d6944));
        for (int i = 0; i < 128; i++) begin
            mem_s[i] = 4'($urandom);
            u_mem.mem[i] = mem_s[i];
        end
        for (int i = 0; i < 16; i++) begin
            reg_s[i] = 4'($urandom);
            u_mem.rf[i] = reg_s[i];
        end
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        // mask boundaries on every op, each skip drops its follower
        for (int k = 0; k < 20; k++) begin
            run_op(ops[k % 10], 3'($urandom), 4'($urandom), (k < 10) ? 4'h0 : 4'hf);
        end
        // equality hits for both compares
        run_op(OP_SKIP_EQUAL, 3'h2, 4'h5, mem_s[7'h25]);
        run_op(OP_XOR_MI, 3'h2, 4'h5, 4'hf);
        run_op(OP_SKIP_UNEQUAL, 3'h2, 4'h5, mem_s[7'h25]);
        // compare flag: set, then cleared by bit tests only
        for (int k = 5; k < 8; k++) begin
            compare_flag_set = 1'b1;
            @(posedge clk);
            #1;
            compare_flag_set = 1'b0;
            ef = !(k > 5 && !skip_s);
            run_op(ops[k], 3'($urandom), 4'($urandom), 4'($urandom));
            check({7'h00, compare_only_flag_r}, {7'h00, ef});
        end
        // outside set held across a bit test: set beats the clear
        compare_flag_set = 1'b1;
        run_op(OP_SKIP_BITS_CLEAR, 3'h1, 4'h3, 4'h9);
        compare_flag_set = 1'b0;
        check({7'h00, compare_only_flag_r}, 8'h01);
        // random stream, unknown codes and indexed addressing mixed in
        for (int k = 0; k < 400; k++) begin
            index_enable_flag = ($urandom % 4) == 0;
            index_register = 7'($urandom);
            op = ($urandom % 6 == 0) ? 5'($urandom) : ops[$urandom % 10];
            run_op(op, 3'($urandom), 4'($urandom), 4'($urandom));
        end
        report_and_stop();
    end

    initial begin
        #100000;
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule
